// file: common/dhbi_map.vh
// register map, field positions, reset values and timing constants for the host front end
`ifndef DHBI_MAP_VH
`define DHBI_MAP_VH

`define DHBI_ADDR_MODE_ZERO_CHAN_A 4'h0
`define DHBI_ADDR_MODE_ZERO_CHAN_B 4'h8
`define DHBI_ADDR_CSRA 4'h1
`define DHBI_ADDR_CSRB 4'h9
`define DHBI_ADDR_ISR 4'h5
`define DHBI_ADDR_IMR 4'h5
`define DHBI_ADDR_OPCR 4'hd
`define DHBI_ADDR_IVR 4'hc
`define DHBI_ADDR_CTU 4'h6
`define DHBI_ADDR_CTL 4'h7
`define DHBI_ADDR_IPCFG 4'he

`define DHBI_IVR_RST 8'h0f
`define DHBI_ZERO8 8'h00
`define DHBI_MR0_EXT_BIT 0
`define DHBI_MR0_DEPTH_BIT 3
`define DHBI_MR0_EXT_LSB 0
`define DHBI_MR0_EXT_MSB 2
`define DHBI_ISR_TXB_BIT 4
`define DHBI_ISR_RXB_BIT 5
`define DHBI_ISR_TXA_BIT 0
`define DHBI_ISR_RXA_BIT 1
`define DHBI_ISR_CT_BIT 3

`define DHBI_DEPTH_SHALLOW 5'h08
`define DHBI_DEPTH_DEEP 5'h10
`define DHBI_ACK_EDGES 2'h2

`define DHBI_CLKSEL_EXT 4'hf
`define DHBI_CLKSEL_CT 4'he
`define DHBI_NUM_RATES 5'h1c

`endif

// file: rtl/dhbi_baud_gen.v
// baud generator: one 16x enable pulse per rate, derived from the crystal clock
`timescale 1ns/1ps
module dhbi_baud_gen #(
  parameter NRATES = 32,
  parameter DW = 16
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire [NRATES*DW-1:0] i_divisors,
  output wire [NRATES-1:0] o_rate_en
);
  // divisors are counts of crystal clocks per 16x tick, so every rate scales
  // in proportion to the crystal frequency
  genvar g;
  generate
    for (g = 0; g < NRATES; g = g + 1) begin : g_rate
      reg [DW-1:0] cnt_r;
      wire [DW-1:0] div_w = i_divisors[g*DW +: DW];
      always @(posedge i_clk_sys) begin
        if (i_rst) begin
          cnt_r <= {DW{1'b0}};
        end else if (cnt_r >= div_w - 1'b1) begin
          cnt_r <= {DW{1'b0}};
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
      assign o_rate_en[g] = (cnt_r == {DW{1'b0}}) && (div_w != {DW{1'b0}});
    end
  endgenerate
endmodule

// file: rtl/dhbi_host_port.v
// acknowledge-style host port, interrupt control, fifo depth and clock selection
`timescale 1ns/1ps
// What this block does
// R1: pin seven mirrors channel b tx interrupt
// R2: input pins zero/one: gpio or cts
// R3: input pin two: gpio or timer clock
// R4: external tx clock shifts on falling edge
// R5: external rx clock samples on rising edge
// R6: acknowledge cycle drives vector and acknowledge
// R7: single active-low interrupt from eight conditions
// R8: mask selects which conditions interrupt
// R9: status register shows active conditions
// R10: interrupt pins become open-drain active low
// R11: fifo fill limit 8 or 16
// R12: one depth bit, thresholds follow it
// R13: grounded mode pin selects acknowledge bus
// R14: vector register at 0xc, reset 0x0f
// R15: acknowledge after two clock edges
// R16: early chip-select release aborts acknowledge
// R17: generator outputs are 16x rates
// R18: mode bit 0 adds fast rates
// R19: channel a field governs both channels
// R20: four selectors pick rate or external, except rx b, which has no external clock
// R21: rates scale with crystal clock
// R22: counter/timer divides clock for 16x
// R23: host drives read high, write low
// R24: reset clears mask, status, config
// R25: release acknowledge and bus on deassert
`include "dhbi_map.vh"
module dhbi_host_port #(
  parameter NRATES = 32,
  parameter DW = 16,
  parameter [NRATES*DW-1:0] RATE_DIVISORS = {NRATES{16'h0018}}
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_mode_sel,
  input wire i_chip_select_n,
  input wire i_read_strobe_n,
  input wire i_write_strobe_n,
  input wire [3:0] i_addr,
  input wire [7:0] i_data,
  output reg [7:0] o_data,
  output wire o_data_oe,
  output wire o_transfer_acknowledge_n,
  output wire o_transfer_acknowledge_oe,
  input wire [6:0] i_input_pins,
  input wire [7:0] i_isr_events,
  output wire o_irq_request_n_oe,
  output wire [7:0] o_output_pins,
  output wire [7:0] o_output_pins_oe,
  output wire [4:0] o_fifo_limit,
  output wire o_cts_a_n,
  output wire o_cts_b_n,
  output wire o_ct_ext_clk_en,
  output wire o_tx_clk_en_a,
  output wire o_rx_clk_en_a,
  output wire o_tx_clk_en_b,
  output wire o_rx_clk_en_b,
  output wire [7:0] o_input_port
);
  //----------------------------------------
  // pin synchronisers
  //----------------------------------------
  reg [10:0] sync1_r;
  reg [10:0] sync2_r;
  reg [6:0] ip_d_r;
  always @(posedge i_clk_sys) begin
    sync1_r <= {i_mode_sel, i_chip_select_n, i_read_strobe_n, i_write_strobe_n, i_input_pins};
    sync2_r <= sync1_r;
  end
  wire [6:0] ip_s = sync2_r[6:0];
  wire wrn_s = sync2_r[7];
  wire rdn_s = sync2_r[8];
  wire csn_s = sync2_r[9];
  wire ack_mode = ~sync2_r[10]; // R13
  // in ack mode the write strobe pin carries read/write select
  wire rw_sel = wrn_s; // R13 R23
  wire iack_n = ack_mode ? ip_s[6] : 1'b1; // R13
  // edge history follows the pins through reset too, so no false edge follows it
  always @(posedge i_clk_sys) begin
    ip_d_r <= ip_s;
  end
  //----------------------------------------
  // registers
  //----------------------------------------
  reg [7:0] mode_zero_chan_a_r;
  reg [7:0] mode_zero_chan_b_r;
  reg [7:0] csra_r;
  reg [7:0] csrb_r;
  reg [7:0] imr_r;
  reg [7:0] isr_r;
  reg [7:0] opcr_r;
  reg [7:0] ivr_r;
  reg [7:0] ipcfg_r;
  reg [15:0] ct_div_r;
  //----------------------------------------
  // bus cycle sequencer
  //----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_ACK = 2'h2;
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [1:0] edge_r;
  reg iack_cyc_r;
  wire sel_n = csn_s & iack_n;
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (ack_mode && !sel_n) begin
          st_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (sel_n) begin
          st_nxt = ST_IDLE; // R16
        end else if (edge_r == `DHBI_ACK_EDGES - 2'h1) begin
          st_nxt = ST_ACK; // R15
        end
      end
      ST_ACK: begin
        if (sel_n) begin
          st_nxt = ST_IDLE; // R25
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r <= ST_IDLE;
      edge_r <= 2'h0;
      iack_cyc_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_r == ST_IDLE) begin
        edge_r <= 2'h0;
        iack_cyc_r <= ~iack_n;
      end else if (st_r == ST_WAIT) begin
        edge_r <= edge_r + 2'h1;
      end
    end
  end
  wire ack_on = (st_r == ST_ACK);
  assign o_transfer_acknowledge_n = ~ack_on; // R15
  assign o_transfer_acknowledge_oe = ack_mode;
  wire is_read = iack_cyc_r | rw_sel;
  assign o_data_oe = ack_on & is_read; // R25
  // writes commit once, on the move into the acknowledge state
  wire wr_stb = (st_r == ST_WAIT) && (st_nxt == ST_ACK) && !iack_cyc_r && !rw_sel;
  //----------------------------------------
  // register writes and status
  //----------------------------------------
  wire imr_wr = wr_stb && (i_addr == `DHBI_ADDR_IMR);
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      mode_zero_chan_a_r <= `DHBI_ZERO8;
      mode_zero_chan_b_r <= `DHBI_ZERO8;
      csra_r <= `DHBI_ZERO8;
      csrb_r <= `DHBI_ZERO8;
      imr_r <= `DHBI_ZERO8; // R24
      opcr_r <= `DHBI_ZERO8; // R24
      ivr_r <= `DHBI_IVR_RST; // R14
      ipcfg_r <= `DHBI_ZERO8;
      ct_div_r <= 16'h0000;
    end else if (wr_stb) begin
      if (i_addr == `DHBI_ADDR_MODE_ZERO_CHAN_A) begin
        mode_zero_chan_a_r <= i_data;
      end else if (i_addr == `DHBI_ADDR_MODE_ZERO_CHAN_B) begin
        mode_zero_chan_b_r <= i_data;
      end else if (i_addr == `DHBI_ADDR_CSRA) begin
        csra_r <= i_data;
      end else if (i_addr == `DHBI_ADDR_CSRB) begin
        csrb_r <= i_data;
      end else if (imr_wr) begin
        imr_r <= i_data; // R8
      end else if (i_addr == `DHBI_ADDR_OPCR) begin
        opcr_r <= i_data;
      end else if (i_addr == `DHBI_ADDR_IVR) begin
        ivr_r <= i_data; // R14
      end else if (i_addr == `DHBI_ADDR_IPCFG) begin
        ipcfg_r <= i_data;
      end else if (i_addr == `DHBI_ADDR_CTU) begin
        ct_div_r[15:8] <= i_data;
      end else if (i_addr == `DHBI_ADDR_CTL) begin
        ct_div_r[7:0] <= i_data;
      end
    end
  end
  // status follows the live channel conditions; the channels own their clearing
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      isr_r <= `DHBI_ZERO8; // R24
    end else begin
      isr_r <= i_isr_events; // R9
    end
  end
  //----------------------------------------
  // read data
  //----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_data <= `DHBI_ZERO8;
    end else if (st_r == ST_WAIT) begin
      if (iack_cyc_r) begin
        o_data <= ivr_r; // R6
      end else if (i_addr == `DHBI_ADDR_MODE_ZERO_CHAN_A) begin
        o_data <= mode_zero_chan_a_r;
      end else if (i_addr == `DHBI_ADDR_MODE_ZERO_CHAN_B) begin
        o_data <= {mode_zero_chan_b_r[7:3], 3'h0}; // R19
      end else if (i_addr == `DHBI_ADDR_ISR) begin
        o_data <= isr_r; // R9
      end else if (i_addr == `DHBI_ADDR_IVR) begin
        o_data <= ivr_r;
      end else if (i_addr == `DHBI_ADDR_OPCR) begin
        o_data <= opcr_r;
      end else if (i_addr == `DHBI_ADDR_IPCFG) begin
        o_data <= ipcfg_r;
      end else if (i_addr == `DHBI_ADDR_CSRA) begin
        o_data <= csra_r;
      end else if (i_addr == `DHBI_ADDR_CSRB) begin
        o_data <= csrb_r;
      end else begin
        o_data <= {1'b0, ip_s};
      end
    end
  end
  //----------------------------------------
  // interrupt outputs
  //----------------------------------------
  wire [7:0] active = isr_r & imr_r;
  // open-drain: only ever pulled low
  assign o_irq_request_n_oe = |active; // R7 R8
  // opcr bits 7..3 turn pins 7..3 into discrete interrupt pins
  wire [4:0] irq_src = {isr_r[`DHBI_ISR_TXB_BIT], isr_r[`DHBI_ISR_TXA_BIT],
                        isr_r[`DHBI_ISR_RXB_BIT], isr_r[`DHBI_ISR_RXA_BIT],
                        isr_r[`DHBI_ISR_CT_BIT]};
  genvar p;
  generate
    for (p = 3; p < 8; p = p + 1) begin : g_op
      assign o_output_pins[p] = 1'b0; // R10
      assign o_output_pins_oe[p] = opcr_r[p] ? irq_src[p-3] : 1'b1; // R1 R10
    end
    for (p = 0; p < 3; p = p + 1) begin : g_op_lo
      assign o_output_pins[p] = 1'b1;
      assign o_output_pins_oe[p] = 1'b1;
    end
  endgenerate
  //----------------------------------------
  // input pin functions and fifo depth
  //----------------------------------------
  assign o_cts_a_n = ipcfg_r[0] ? ip_s[0] : 1'b0; // R2
  assign o_cts_b_n = ipcfg_r[1] ? ip_s[1] : 1'b0; // R2
  assign o_ct_ext_clk_en = ipcfg_r[2] & ip_d_r[2] & ~ip_s[2]; // R3
  assign o_input_port = {1'b0, ip_s};
  assign o_fifo_limit = mode_zero_chan_a_r[`DHBI_MR0_DEPTH_BIT] ?
                        `DHBI_DEPTH_DEEP : `DHBI_DEPTH_SHALLOW; // R11 R12
  //----------------------------------------
  // clock selection
  //----------------------------------------
  wire [NRATES-1:0] rate_en;
  dhbi_baud_gen #(
    .NRATES(NRATES),
    .DW(DW)
  ) u_baud_gen (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_divisors(RATE_DIVISORS), // R17 R21
    .o_rate_en(rate_en)
  );
  // counter/timer runs as a square wave of half period ct_div_r; its high-to-low
  // transition is the 16x tick, so the tick period is twice the divisor
  reg [15:0] ct_cnt_r;
  reg ct_phase_r;
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      ct_cnt_r <= 16'h0000;
      ct_phase_r <= 1'b0;
    end else if (ct_cnt_r <= 16'h0001) begin
      ct_cnt_r <= ct_div_r; // R22
      ct_phase_r <= ~ct_phase_r;
    end else begin
      ct_cnt_r <= ct_cnt_r - 16'h0001;
    end
  end
  wire ct_tick = (ct_cnt_r == 16'h0001) && ct_phase_r; // R22
  function sel_clk;
    input [3:0] code;
    input ext_edge;
    input ext_ok;
    input [NRATES-1:0] rates;
    input [2:0] ext_field;
    input ct;
    reg [4:0] idx;
    begin
      idx = {1'b0, code};
      // extended rate field lifts every rate code (0x0 to 0xd) to the fast table half; the external and counter/timer codes ignore it
      if (ext_field[`DHBI_MR0_EXT_BIT]) begin
        idx = {1'b1, code}; // R18
      end
      if (code == `DHBI_CLKSEL_EXT) begin
        sel_clk = ext_ok & ext_edge;
      end else if (code == `DHBI_CLKSEL_CT) begin
        sel_clk = ct;
      end else begin
        sel_clk = rates[idx];
      end
    end
  endfunction
  wire [2:0] ext_field = mode_zero_chan_a_r[`DHBI_MR0_EXT_MSB:`DHBI_MR0_EXT_LSB]; // R19
  wire fall3 = ip_d_r[3] & ~ip_s[3]; // R4
  wire rise4 = ~ip_d_r[4] & ip_s[4]; // R5
  wire fall5 = ip_d_r[5] & ~ip_s[5]; // R4
  assign o_tx_clk_en_a = sel_clk(csra_r[3:0], fall3, 1'b1, rate_en, ext_field, ct_tick); // R20
  assign o_rx_clk_en_a = sel_clk(csra_r[7:4], rise4, 1'b1, rate_en, ext_field, ct_tick); // R20
  assign o_tx_clk_en_b = sel_clk(csrb_r[3:0], fall5, 1'b1, rate_en, ext_field, ct_tick); // R20
  assign o_rx_clk_en_b = sel_clk(csrb_r[7:4], 1'b0, 1'b0, rate_en, ext_field, ct_tick); // R20
endmodule

// file: bench/dhbi_host_port_assertions.sv
// pin-level assertions for the host port
`timescale 1ns/1ps
module dhbi_chk (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_mode_sel,
  input wire i_chip_select_n,
  input wire [6:0] i_input_pins,
  input wire [7:0] i_isr_events,
  input wire o_data_oe,
  input wire o_transfer_acknowledge_n,
  input wire o_transfer_acknowledge_oe,
  input wire o_irq_request_n_oe,
  input wire [7:0] o_output_pins,
  input wire [4:0] o_fifo_limit
);
  // ----------------------------------------
  // cycle start is a select or an interrupt acknowledge
  // ----------------------------------------
  wire sel_n = i_chip_select_n & i_input_pins[6];
  default clocking dc @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  AST_ACK_DELAY: assert property ($fell(o_transfer_acknowledge_n) |->
    !$past(sel_n, 1) && !$past(sel_n, 2) && !$past(sel_n, 3))
    else $error("acknowledge came too soon after select");
  AST_ACK_RELEASE: assert property ($rose(sel_n) |->
    ##[1:4] (o_transfer_acknowledge_n && !o_data_oe))
    else $error("acknowledge or data drive held after release");
  AST_OE_WITH_ACK: assert property (o_data_oe |-> !o_transfer_acknowledge_n)
    else $error("data driven outside acknowledge");
  AST_IRQ_IDLE: assert property ((i_isr_events == 8'h00) [*3] |-> !o_irq_request_n_oe)
    else $error("interrupt pulled with no condition");
  AST_OD_LOW: assert property (o_output_pins[7:3] == 5'h00)
    else $error("interrupt pin value not low");
  AST_STROBE_QUIET: assert property (i_mode_sel [*4] |-> o_transfer_acknowledge_n)
    else $error("acknowledge in strobe mode");
  AST_ACK_OE_MODE: assert property ($stable(i_mode_sel) [*3] |->
    o_transfer_acknowledge_oe == !i_mode_sel)
    else $error("acknowledge enable does not follow mode pin");
  AST_FIFO_LIMIT: assert property (o_fifo_limit == 5'h08 || o_fifo_limit == 5'h10)
    else $error("fifo limit not 8 or 16");
  AST_RESET: assert property (disable iff (1'b0) i_rst |=>
    o_transfer_acknowledge_n && !o_data_oe && !o_irq_request_n_oe)
    else $error("outputs active during reset");
endmodule
bind dhbi_host_port dhbi_chk dhbi_chk_inst (.i_clk_sys, .i_rst, .i_mode_sel,
  .i_chip_select_n, .i_input_pins, .i_isr_events, .o_data_oe, .o_transfer_acknowledge_n,
  .o_transfer_acknowledge_oe, .o_irq_request_n_oe, .o_output_pins, .o_fifo_limit);

// file: bench/dhbi_host_cpu.sv
// host cpu model for the acknowledge-style bus
`timescale 1ns/1ps
module dhbi_host_cpu (
  input wire i_clk_sys,
  input wire i_ack_n,
  input wire [7:0] i_rdata,
  output reg o_cs_n = 1'b1,
  output reg o_rw = 1'b1,
  output reg o_iack_n = 1'b1,
  output reg [3:0] o_addr = 4'h0,
  output reg [7:0] o_wdata = 8'h00
);
  // ----------------------------------------
  // one transfer; gives up after 12 edges without acknowledge
  // ----------------------------------------
  task xfer(input iak, input rd, input [3:0] a, input [7:0] d,
    output [7:0] q, output ok);
    integer n;
    begin
      ok = 1'b0;
      q = 8'h00;
      @(posedge i_clk_sys);
      o_addr <= a;
      o_rw <= rd;
      o_wdata <= rd ? ~o_wdata : d;
      if (iak) o_iack_n <= 1'b0;
      else o_cs_n <= 1'b0;
      for (n = 0; n < 12 && !ok; n = n + 1) begin
        @(posedge i_clk_sys);
        if (i_ack_n === 1'b0) begin
          ok = 1'b1;
          q = i_rdata;
        end
      end
      o_cs_n <= 1'b1;
      o_iack_n <= 1'b1;
      // released data bus: show a changed value, not the old one
      o_wdata <= ~o_wdata;
      for (n = 0; n < 8 && i_ack_n !== 1'b1; n = n + 1) @(posedge i_clk_sys);
      @(posedge i_clk_sys);
    end
  endtask
  // select held for one edge only, far short of the acknowledge delay
  task abort(input [3:0] a, input [7:0] d, output ok);
    integer n;
    begin
      ok = 1'b0;
      @(posedge i_clk_sys);
      o_addr <= a;
      o_wdata <= d;
      o_rw <= 1'b0;
      o_cs_n <= 1'b0;
      @(posedge i_clk_sys);
      o_cs_n <= 1'b1;
      for (n = 0; n < 8; n = n + 1) begin
        @(posedge i_clk_sys);
        if (i_ack_n === 1'b0) ok = 1'b1;
      end
    end
  endtask
endmodule

// file: bench/dhbi_testbench.sv
// self-checking bench for the host port
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
  checked = checked + 1; \
  if ((a) !== (e)) begin \
    mismatches = mismatches + 1; \
    $display("MISMATCH %s exp %h seen %h", n, e, a); \
  end \
end
module testbench;
  reg i_clk_sys;
  reg i_rst = 1'b1;
  reg mode = 1'b0;
  reg [5:0] pins = 6'h00;
  reg [7:0] ev = 8'h00;
  reg [7:0] q;
  reg ok;
  wire cs_n, rw, iack_n, ack_n, ack_oe, d_oe, irq_oe, tx_en, rx_en, cts_a_n, cts_b_n, ct_ext;
  wire [3:0] addr;
  wire [7:0] wdata, rdata, op, op_oe, in_port;
  wire [4:0] flim;
  integer mismatches = 0, checked = 0, cycles = 0, i, ntx = 0, nrx = 0, nct = 0;
  // rate slot 0 and its fast twin, slot 16, get distinct divisors
  localparam [511:0] DIVS = {{15{16'h0018}}, 16'h0008, {15{16'h0018}}, 16'h0010};
  dhbi_host_port #(.RATE_DIVISORS(DIVS)) dhbi_host_port_inst (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_mode_sel(mode), .i_chip_select_n(cs_n), .i_read_strobe_n(1'b1),
    .i_write_strobe_n(rw), .i_addr(addr), .i_data(wdata), .o_data(rdata),
    .o_data_oe(d_oe), .o_transfer_acknowledge_n(ack_n),
    .o_transfer_acknowledge_oe(ack_oe), .i_input_pins({iack_n, pins}),
    .i_isr_events(ev), .o_irq_request_n_oe(irq_oe), .o_output_pins(op),
    .o_output_pins_oe(op_oe), .o_fifo_limit(flim), .o_cts_a_n(cts_a_n),
    .o_cts_b_n(cts_b_n), .o_ct_ext_clk_en(ct_ext), .o_tx_clk_en_a(tx_en),
    .o_rx_clk_en_a(rx_en), .o_tx_clk_en_b(), .o_rx_clk_en_b(), .o_input_port(in_port));
  dhbi_host_cpu dhbi_host_cpu_inst (.i_clk_sys(i_clk_sys), .i_ack_n(ack_n),
    .i_rdata(rdata), .o_cs_n(cs_n), .o_rw(rw), .o_iack_n(iack_n), .o_addr(addr),
    .o_wdata(wdata));
  // ----------------------------------------
  // clock, cycle limit and helpers
  // ----------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  task rd(input [3:0] a);
    dhbi_host_cpu_inst.xfer(1'b0, 1'b1, a, 8'h00, q, ok);
  endtask
  task wr(input [3:0] a, input [7:0] d);
    dhbi_host_cpu_inst.xfer(1'b0, 1'b0, a, d, q, ok);
  endtask
  task settle;
    repeat (6) @(posedge i_clk_sys);
  endtask
  // counts enable pulses over n edges, sampled once per edge
  task count_en(input integer n);
    begin
      ntx = 0;
      nrx = 0;
      nct = 0;
      repeat (n) begin
        @(posedge i_clk_sys);
        ntx = ntx + tx_en;
        nrx = nrx + rx_en;
        nct = nct + ct_ext;
      end
    end
  endtask
  task do_reset;
    begin
      i_rst <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    do_reset;
    `CHK("fifo_rst", 5'h08, flim)
    `CHK("ack_oe", 1'b1, ack_oe)
    rd(4'hc);
    `CHK("vector_rst", 8'h0f, q)
    wr(4'hc, 8'ha5);
    dhbi_host_cpu_inst.xfer(1'b1, 1'b1, 4'h0, 8'h00, q, ok);
    `CHK("iack_vector", 8'ha5, q)
    dhbi_host_cpu_inst.abort(4'hc, 8'h3c, ok);
    `CHK("abort_ack", 1'b0, ok)
    rd(4'hc);
    `CHK("abort_kept", 8'ha5, q)
    ev <= 8'hff;
    settle;
    `CHK("mask_rst", 1'b0, irq_oe)
    for (i = 0; i < 8; i = i + 1) begin
      ev <= 8'h01 << i;
      wr(4'h5, 8'h01 << i);
      `CHK("irq", 1'b1, irq_oe)
      rd(4'h5);
      `CHK("status", 8'h01 << i, q)
      wr(4'h5, ~(8'h01 << i));
      `CHK("masked", 1'b0, irq_oe)
    end
    wr(4'hd, 8'h80);
    ev <= 8'h10;
    settle;
    `CHK("op7_oe", 1'b1, op_oe[7])
    `CHK("op7_val", 1'b0, op[7])
    ev <= 8'h00;
    settle;
    `CHK("op7_idle", 1'b0, op_oe[7])
    wr(4'h8, 8'h08);
    `CHK("fifo_b", 5'h08, flim)
    wr(4'h0, 8'h08);
    `CHK("fifo_a", 5'h10, flim)
    wr(4'h1, 8'hff);
    settle;
    pins <= 6'h18;
    count_en(6);
    `CHK("tx_rise", 0, ntx)
    `CHK("rx_rise", 1, nrx)
    pins <= 6'h00;
    count_en(6);
    `CHK("tx_fall", 1, ntx)
    `CHK("rx_fall", 0, nrx)
    wr(4'h1, 8'h00);
    count_en(96);
    `CHK("rate_tx", 6, ntx)
    `CHK("rate_rx", 6, nrx)
    wr(4'h8, 8'h09);
    count_en(96);
    `CHK("rate_b_field", 6, ntx)
    rd(4'h8);
    `CHK("mode_zero_chan_b_rsvd", 8'h08, q)
    wr(4'h0, 8'h09);
    count_en(96);
    `CHK("rate_fast", 12, ntx)
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h03);
    wr(4'h1, 8'h0e);
    count_en(96);
    `CHK("ct_rate", 16, ntx)
    `CHK("rx_own_rate", 12, nrx)
    pins <= 6'h03;
    settle;
    `CHK("cts_off", 2'h0, {cts_a_n, cts_b_n})
    `CHK("gpio", 8'h43, in_port)
    wr(4'he, 8'h07);
    pins <= 6'h01;
    settle;
    `CHK("cts_on", 2'h2, {cts_a_n, cts_b_n})
    pins <= 6'h04;
    count_en(6);
    `CHK("ct_ext_rise", 0, nct)
    pins <= 6'h00;
    count_en(6);
    `CHK("ct_ext_fall", 1, nct)
    ev <= 8'hff;
    wr(4'h5, 8'hff);
    do_reset;
    `CHK("irq_rst", 1'b0, irq_oe)
    rd(4'hd);
    `CHK("opcr_rst", 8'h00, q)
    rd(4'hc);
    `CHK("vector_again", 8'h0f, q)
    mode <= 1'b1;
    settle;
    `CHK("strobe_oe", 1'b0, ack_oe)
    rd(4'hc);
    `CHK("strobe_ack", 1'b0, ok)
    complete_run;
  end
endmodule
